// *** logic/gts_pkg.sv ***
// shared constants, types and helpers of the gps time-status packet builder
`default_nettype none
package gts_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 200_000_000; // system clock rate
  localparam int US_PER_S = 1_000_000; // microseconds in a second
  localparam int NMEA_TIMEOUT_S = 2; // sentence lock lost after over this
  // ----------------------------------------------------------------
  // frame layout (lengths in bytes, P_ indices from first payload byte)
  // ----------------------------------------------------------------
  localparam int HDR_LEN = 42; // link, network and transport header
  localparam int PAY_LEN = 512; // udp payload
  localparam int PKT_LEN = HDR_LEN + PAY_LEN; // whole frame
  localparam int P_DATE = 2; // payload offset of the date digits
  localparam int P_TIME = 8; // payload offset of the time digits
  localparam int P_USEC = 14; // payload offset of the microsecond count
  localparam int P_SENT = 18; // payload offset of raw_sentence_field
  localparam int SENT_LEN = 84; // raw_sentence_field size
  localparam int P_FILL = P_SENT + SENT_LEN; // reserved fill
  localparam int P_STAT = 506; // position_status_byte
  localparam int P_LOCK = 507; // timing_pulse_lock_indicator
  // ----------------------------------------------------------------
  // header field values
  // ----------------------------------------------------------------
  localparam logic [15:0] TB_HEAD = 16'hFFEE; // time_block opener
  localparam logic [15:0] ETH_TYPE = 16'h0800; // ipv4
  localparam logic [31:0] SRC_IP_DEF = 32'hC0A8_01C9; // default source ip
  localparam logic [31:0] DST_IP = 32'hFFFF_FFFF; // broadcast
  localparam logic [15:0] SRC_PORT = 16'h2710;
  localparam logic [15:0] DST_PORT = 16'h277E;
  localparam logic [15:0] UDP_LEN = 16'h0208; // 8 + 512
  localparam logic [15:0] IP_LEN = 16'h021C; // 20 + 520
  localparam logic [7:0] FILL_BYTE = 8'hDF;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] year; // two-digit year
    logic [7:0] month;
    logic [7:0] day;
    logic [7:0] hour;
    logic [7:0] minute;
    logic [7:0] second;
  } gts_time_s;
  localparam gts_time_s TIME_RST = '{8'h14, 8'h05, 8'h14, 8'h00, 8'h00, 8'h00};
  typedef enum logic [3:0] {
    PS_IDLE = 4'h1, // waiting for a dollar sign
    PS_BODY = 4'h2, // inside the sentence
    PS_CK1 = 4'h4, // first checksum digit
    PS_CK2 = 4'h8 // second checksum digit
  } gts_ps_e;
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // one's complement header sum for a given source ip
  function automatic logic [15:0] ip_csum(input logic [31:0] sip);
    logic [19:0] s;
    s = 20'h04500 + 20'(IP_LEN) + 20'h04000 + 20'h08011 + 20'(sip[31:16])
      + 20'(sip[15:0]) + 20'(DST_IP[31:16]) + 20'(DST_IP[15:0]);
    s = 20'(s[15:0]) + 20'(s[19:16]);
    s = 20'(s[15:0]) + 20'(s[19:16]);
    return ~s[15:0];
  endfunction
  // advance a date and time by one second, with month and leap rollover
  function automatic gts_time_s inc_sec(input gts_time_s t);
    gts_time_s r;
    logic [7:0] dim;
    r = t;
    case (t.month)
      8'h02: dim = (t.year[1:0] == 2'b00) ? 8'h1D : 8'h1C;
      8'h04, 8'h06, 8'h09, 8'h0B: dim = 8'h1E;
      default: dim = 8'h1F;
    endcase
    r.second = t.second + 8'h01;
    if (t.second >= 8'h3B) begin
      r.second = 8'h00;
      r.minute = t.minute + 8'h01;
      if (t.minute >= 8'h3B) begin
        r.minute = 8'h00;
        r.hour = t.hour + 8'h01;
        if (t.hour >= 8'h17) begin
          r.hour = 8'h00;
          r.day = t.day + 8'h01;
          if (t.day >= dim) begin
            r.day = 8'h01;
            r.month = (t.month >= 8'h0C) ? 8'h01 : t.month + 8'h01;
            if (t.month >= 8'h0C) r.year = (t.year >= 8'h63) ? 8'h00 : t.year + 8'h01;
          end
        end
      end
    end
    return r;
  endfunction
  // ascii digit of a value below one hundred, tens or ones
  function automatic logic [7:0] asc(input logic [7:0] v, input logic tens);
    return 8'h30 + (tens ? v / 8'h0A : v % 8'h0A);
  endfunction
endpackage
`default_nettype wire

// *** logic/gts_packet_builder.sv ***
// gps time keeper and one-per-second udp time-status frame builder
`timescale 1ns/1ps
`default_nettype none
module gts_packet_builder #(
  parameter int CLK_HZ = gts_pkg::CLK_HZ, // cycles per second
  parameter logic [47:0] SRC_MAC = 48'h02_00_00_00_00_01, // arbitrary value
  parameter logic [31:0] SRC_IP = gts_pkg::SRC_IP_DEF // source address
) (
  input wire logic CLK, // system clock
  input wire logic SYS_RST, // async reset, active high
  input wire logic PPS_IN, // pulse per second pin
  input wire logic [7:0] NMEA_DATA, // received sentence character
  input wire logic NMEA_VALID, // character strobe
  output logic [7:0] TX_DATA, // frame byte
  output logic TX_VALID, // frame byte valid
  output logic TX_LAST, // last byte of the frame
  input wire logic TX_READY, // sink takes the byte
  output gts_pkg::gts_time_s STAMP, // point-cloud date and time
  output logic [31:0] STAMP_USEC, // point-cloud microseconds
  output logic PULSE_LOCK, // tick locked to the pulse
  output logic SENTENCE_LOCK, // valid sentences arriving
  output logic SECOND_TICK // one-cycle internal tick
);
  // ----------------------------------------------------------------
  // derived constants
  // ----------------------------------------------------------------
  localparam int CYC_US = CLK_HZ / gts_pkg::US_PER_S; // cycles per us
  localparam logic [31:0] LIM_FREE = 32'(CLK_HZ - 1); // free-run period
  localparam logic [31:0] LIM_LOCK = 32'(CLK_HZ + CLK_HZ / 8); // late-pulse slack
  localparam logic [7:0] US_LAST = 8'(CYC_US - 1);
  localparam logic [31:0] US_MAX = 32'(gts_pkg::US_PER_S - 1);
  localparam logic [335:0] HDR = {48'hFFFF_FFFF_FFFF, SRC_MAC, gts_pkg::ETH_TYPE,
    16'h4500, gts_pkg::IP_LEN, 16'h0000, 16'h4000, 8'h80, 8'h11,
    gts_pkg::ip_csum(SRC_IP), SRC_IP, gts_pkg::DST_IP, gts_pkg::SRC_PORT,
    gts_pkg::DST_PORT, gts_pkg::UDP_LEN, 16'h0000};
  if (CLK_HZ % gts_pkg::US_PER_S != 0 || CYC_US < 2 || CYC_US > 255) begin : g_bad
    $error("CLK_HZ must be a whole number of MHz from 2 to 255");
  end
  // ----------------------------------------------------------------
  // pulse synchroniser and internal one-second tick
  // ----------------------------------------------------------------
  logic pps_m, pps_s, pps_d; // two-flop sync then edge history
  logic [31:0] cyc, next_cyc; // cycles since last tick
  logic [7:0] udiv, next_udiv; // microsecond divider
  logic [31:0] usec, next_usec; // microsecond count
  logic plock, next_plock; // pulse lock
  logic tick, pps_rise;
  // tick on pulse edge, or free-running when no pulse comes in time
  always_comb
  begin
    pps_rise = pps_s & ~pps_d;
    tick = pps_rise | (cyc >= (plock ? LIM_LOCK : LIM_FREE));
    next_plock = pps_rise ? 1'b1 : (tick ? 1'b0 : plock);
    next_cyc = tick ? 32'h0 : cyc + 32'h1;
    next_udiv = (tick || udiv == US_LAST) ? 8'h00 : udiv + 8'h01;
    next_usec = usec;
    if (tick)
      next_usec = 32'h0;
    else if (udiv == US_LAST && usec != US_MAX)
      next_usec = usec + 32'h1;
  end
  // register the tick group
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST) begin
      pps_m <= 1'b0;
      pps_s <= 1'b0;
      pps_d <= 1'b0;
      cyc <= 32'h0;
      udiv <= 8'h00;
      usec <= 32'h0;
      plock <= 1'b0;
    end else begin
      pps_m <= PPS_IN;
      pps_s <= pps_m;
      pps_d <= pps_s;
      cyc <= next_cyc;
      udiv <= next_udiv;
      usec <= next_usec;
      plock <= next_plock;
    end
  end
  // ----------------------------------------------------------------
  // sentence parser
  // ----------------------------------------------------------------
  gts_pkg::gts_ps_e ps, next_ps;
  logic [7:0] ck, next_ck; // running xor
  logic [3:0] fld, next_fld; // comma field number
  logic [2:0] pos, next_pos; // character within field, saturating
  logic rmc, next_rmc, gga, next_gga, r2, next_r2; // sentence kind
  logic [23:0] tdig, next_tdig, ddig, next_ddig; // hhmmss, ddmmyy digits
  logic [7:0] stat, next_stat; // status character
  logic [3:0] ckhi, next_ckhi; // first checksum digit
  logic [6:0] wp, next_wp; // raw sentence write index
  logic wb, next_wb, sb, next_sb; // write and shown banks
  logic [6:0] slen, next_slen; // shown sentence length
  logic s_ok, s_bad; // sentence end events
  logic [7:0] c;
  logic [3:0] hx;
  logic [7:0] mem [2][gts_pkg::SENT_LEN]; // raw sentence banks
  // character-by-character parse, checksum and capture
  always_comb
  begin
    c = NMEA_DATA;
    hx = (c <= 8'h39) ? c[3:0] : 4'(c[3:0] + 4'h9);
    next_ps = ps;
    {next_ck, next_fld, next_pos, next_rmc, next_gga, next_r2} = {ck, fld, pos, rmc, gga, r2};
    {next_tdig, next_ddig, next_stat, next_ckhi, next_wp} = {tdig, ddig, stat, ckhi, wp};
    {next_wb, next_sb, next_slen} = {wb, sb, slen};
    s_ok = 1'b0;
    s_bad = 1'b0;
    if (NMEA_VALID) begin
      if (wp < 7'(gts_pkg::SENT_LEN)) next_wp = wp + 7'h01;
      unique case (ps)
        gts_pkg::PS_IDLE, gts_pkg::PS_BODY:
        begin
          if (c == 8'h24) begin
            // dollar in idle or body restarts, a broken sentence is dropped
            next_ps = gts_pkg::PS_BODY;
            {next_ck, next_fld, next_pos, next_stat} = {8'h00, 4'h0, 3'h0, 8'h00};
            {next_rmc, next_gga, next_r2, next_wp} = {3'b000, 7'h01};
          end else if (ps == gts_pkg::PS_IDLE) begin
            next_wp = wp;
          end else if (c == 8'h2A) begin
            next_ps = gts_pkg::PS_CK1;
          end else begin
            next_ck = ck ^ c;
            if (c == 8'h2C) begin
              next_fld = (fld == 4'hF) ? fld : fld + 4'h1;
              next_pos = 3'h0;
            end else begin
              if (pos != 3'h7) next_pos = pos + 3'h1;
              if (fld == 4'h0 && pos == 3'h2) next_r2 = (c == 8'h52);
              if (fld == 4'h0 && pos == 3'h3) next_rmc = r2 && (c == 8'h4D);
              if (fld == 4'h0 && pos == 3'h3) next_gga = !r2 && (c == 8'h47);
              if (fld == 4'h1 && pos < 3'h6) next_tdig = {tdig[19:0], c[3:0]};
              if (fld == 4'h9 && rmc && pos < 3'h6) next_ddig = {ddig[19:0], c[3:0]};
              if (pos == 3'h0 && ((rmc && fld == 4'h2) || (gga && fld == 4'h6)))
                next_stat = c;
            end
          end
        end
        gts_pkg::PS_CK1:
        begin
          next_ckhi = hx;
          next_ps = gts_pkg::PS_CK2;
        end
        gts_pkg::PS_CK2:
        begin
          next_ps = gts_pkg::PS_IDLE;
          s_ok = ({ckhi, hx} == ck) && (rmc || gga);
          s_bad = ({ckhi, hx} != ck);
          if (s_ok) begin
            // show the finished bank, write the next one into the other
            {next_sb, next_wb, next_slen} = {wb, ~wb, next_wp};
          end
        end
        default: next_ps = gts_pkg::PS_IDLE;
      endcase
    end
  end
  // register the parser group
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST) begin
      ps <= gts_pkg::PS_IDLE;
      {ck, fld, pos, rmc, gga, r2} <= '0;
      {tdig, ddig, stat, ckhi, wp} <= '0;
      {wb, sb, slen} <= '0;
    end else begin
      ps <= next_ps;
      {ck, fld, pos, rmc, gga, r2} <= {next_ck, next_fld, next_pos, next_rmc, next_gga, next_r2};
      {tdig, ddig, stat, ckhi, wp} <= {next_tdig, next_ddig, next_stat, next_ckhi, next_wp};
      {wb, sb, slen} <= {next_wb, next_sb, next_slen};
    end
  end
  // raw character store, no reset needed for plain storage
  always_ff @(posedge CLK)
  begin
    if (NMEA_VALID && ps != gts_pkg::PS_IDLE && wp < 7'(gts_pkg::SENT_LEN))
      mem[wb][wp] <= c;
    if (NMEA_VALID && c == 8'h24)
      mem[wb][0] <= c;
  end
  // ----------------------------------------------------------------
  // time keeping and sentence lock
  // ----------------------------------------------------------------
  gts_pkg::gts_time_s cur, next_cur, ptm, next_ptm; // current, last parsed
  logic pend, next_pend; // parsed time waits for the next tick
  logic slock, next_slock;
  logic [1:0] age, next_age; // ticks since last good sentence
  logic [7:0] pstat, next_pstat; // status of last good sentence
  // ticks advance time; a fresh sentence replaces it, plus one second
  always_comb
  begin
    {next_cur, next_ptm, next_pend} = {cur, ptm, pend};
    {next_slock, next_age, next_pstat} = {slock, age, pstat};
    if (tick) begin
      // the sentence describes the second already begun when it arrives
      next_cur = gts_pkg::inc_sec(pend ? ptm : cur);
      next_pend = 1'b0;
      if (age != 2'(gts_pkg::NMEA_TIMEOUT_S + 1)) next_age = age + 2'h1;
      if (age >= 2'(gts_pkg::NMEA_TIMEOUT_S)) next_slock = 1'b0;
    end
    if (s_ok) begin
      next_ptm = cur; // gga carries no date, keep the running one
      next_ptm.hour = 8'(tdig[23:20] * 4'hA + tdig[19:16]);
      next_ptm.minute = 8'(tdig[15:12] * 4'hA + tdig[11:8]);
      next_ptm.second = 8'(tdig[7:4] * 4'hA + tdig[3:0]);
      if (rmc) begin
        next_ptm.day = 8'(ddig[23:20] * 4'hA + ddig[19:16]);
        next_ptm.month = 8'(ddig[15:12] * 4'hA + ddig[11:8]);
        next_ptm.year = 8'(ddig[7:4] * 4'hA + ddig[3:0]);
      end
      {next_pend, next_slock, next_age, next_pstat} = {2'b11, 2'h0, stat};
    end else if (s_bad) begin
      next_slock = 1'b0;
    end
  end
  // register the time group
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST) begin
      cur <= gts_pkg::TIME_RST;
      ptm <= gts_pkg::TIME_RST;
      {pend, slock, age, pstat} <= '0;
    end else begin
      {cur, ptm, pend, slock, age, pstat} <= {next_cur, next_ptm, next_pend,
        next_slock, next_age, next_pstat};
    end
  end
  // ----------------------------------------------------------------
  // frame transmitter
  // ----------------------------------------------------------------
  logic req, next_req, busy, next_busy, tick_d; // start request, in frame
  logic [9:0] idx, next_idx; // next byte to load
  gts_pkg::gts_time_s st, next_st; // snapshot for the frame
  logic [31:0] su, next_su;
  logic [7:0] sst, next_sst, bout;
  logic sl, next_sl, sbk, next_sbk;
  logic [6:0] sln, next_sln;
  logic [7:0] dout, next_dout;
  logic vout, next_vout, lout, next_lout;
  logic [9:0] p; // payload index
  // byte of the frame at index idx
  always_comb
  begin
    p = idx - 10'(gts_pkg::HDR_LEN);
    bout = 8'h00; // reserved tail bytes
    if (idx < 10'(gts_pkg::HDR_LEN))
      bout = HDR[(10'(gts_pkg::HDR_LEN) - 10'h1 - idx) * 8 +: 8];
    else if (p < 10'(gts_pkg::P_DATE))
      bout = p[0] ? gts_pkg::TB_HEAD[7:0] : gts_pkg::TB_HEAD[15:8];
    else if (p < 10'(gts_pkg::P_TIME))
      bout = gts_pkg::asc(st[47 - 8 * ((p - 2) >> 1) -: 8], p[0]);
    else if (p < 10'(gts_pkg::P_USEC))
      bout = gts_pkg::asc(st[7 + 8 * ((p - 8) >> 1) -: 8], p[0]);
    else if (p < 10'(gts_pkg::P_SENT))
      bout = su[8 * (p - 14) +: 8];
    else if (p < 10'(gts_pkg::P_FILL))
      bout = (p - 10'(gts_pkg::P_SENT) < 10'(sln)) ? mem[sbk][p - 18] : 8'h00;
    else if (p < 10'(gts_pkg::P_STAT))
      bout = gts_pkg::FILL_BYTE;
    else if (p == 10'(gts_pkg::P_STAT))
      bout = sst;
    else if (p == 10'(gts_pkg::P_LOCK))
      bout = {7'h00, sl};
  end
  // start on the tick after time settles, stream with back-pressure
  always_comb
  begin
    {next_req, next_busy, next_idx} = {req | tick_d, busy, idx};
    {next_st, next_su, next_sst, next_sl, next_sbk, next_sln} = {st, su, sst, sl, sbk, sln};
    {next_dout, next_vout, next_lout} = {dout, vout, lout};
    if (vout && TX_READY) next_vout = 1'b0;
    if (!busy && req) begin
      {next_req, next_busy, next_idx} = {tick_d, 1'b1, 10'h0};
      {next_st, next_su, next_sst} = {cur, usec, pstat};
      {next_sl, next_sbk, next_sln} = {plock, sb, slen};
    end else if (busy && (!vout || TX_READY)) begin
      {next_dout, next_vout} = {bout, 1'b1};
      next_lout = (idx == 10'(gts_pkg::PKT_LEN - 1));
      next_idx = idx + 10'h1;
      next_busy = !next_lout;
    end
  end
  // register the transmitter group
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST) begin
      {req, busy, idx, tick_d} <= '0;
      st <= gts_pkg::TIME_RST;
      {su, sst, sl, sbk, sln} <= '0;
      {dout, vout, lout} <= '0;
    end else begin
      {req, busy, idx, tick_d} <= {next_req, next_busy, next_idx, tick};
      {st, su, sst, sl, sbk, sln} <= {next_st, next_su, next_sst, next_sl, next_sbk, next_sln};
      {dout, vout, lout} <= {next_dout, next_vout, next_lout};
    end
  end
  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign TX_DATA = dout;
  assign TX_VALID = vout;
  assign TX_LAST = lout;
  assign STAMP = cur;
  assign STAMP_USEC = usec;
  assign PULSE_LOCK = plock;
  assign SENTENCE_LOCK = slock;
  assign SECOND_TICK = tick_d;
endmodule // gts_packet_builder
`default_nettype wire

// *** dv/gts_packet_builder_sva.sv ***
// port-level assertions of the gps time-status packet builder
`timescale 1ns/1ps
`default_nettype none
module gts_packet_builder_sva (
  input wire logic CLK, // system clock
  input wire logic SYS_RST, // async reset, active high
  input wire logic PPS_IN, // pulse pin
  input wire logic NMEA_VALID, // character strobe
  input wire logic [7:0] TX_DATA, // frame byte
  input wire logic TX_VALID, // frame byte valid
  input wire logic TX_LAST, // last frame byte
  input wire logic TX_READY, // sink ready
  input wire gts_pkg::gts_time_s STAMP, // current time
  input wire logic [31:0] STAMP_USEC, // microseconds
  input wire logic PULSE_LOCK, // tick locked to pulse
  input wire logic SENTENCE_LOCK, // sentences arriving
  input wire logic SECOND_TICK // tick pulse
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  // ------------------------------------------------------------
  // byte counter of the frame on the stream
  // ------------------------------------------------------------
  logic [9:0] n_byte; // bytes taken in this frame
  logic [9:0] next_n_byte; // count after this edge
  // clears on the last byte; a lost flag fails a_last on byte 553 of the same frame
  always_comb
  begin
    next_n_byte = n_byte;
    if (TX_VALID && TX_READY) next_n_byte = TX_LAST ? 10'h000 : n_byte + 10'h001;
  end
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST) n_byte <= 10'h000;
    else n_byte <= next_n_byte;
  end
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  property p_tick; $rose(PPS_IN) |-> ##[2:6] SECOND_TICK; endproperty
  a_tick: assert property (p_tick) else $error("no tick after pulse");
  property p_usec; SECOND_TICK |-> STAMP_USEC == 32'h0000_0000; endproperty
  a_usec: assert property (p_usec) else $error("usec not cleared");
  property p_frame; SECOND_TICK && !TX_VALID |-> ##3 TX_VALID; endproperty
  a_frame: assert property (p_frame) else $error("no frame after tick");
  property p_hold; TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA); endproperty
  a_hold: assert property (p_hold) else $error("byte dropped in stall");
  property p_first; $rose(TX_VALID) |-> TX_DATA == 8'hFF; endproperty
  a_first: assert property (p_first) else $error("frame opens wrong");
  property p_last; TX_VALID |-> (TX_LAST == (n_byte == 10'h229)); endproperty
  a_last: assert property (p_last) else $error("last flag misplaced");
  property p_step; SECOND_TICK |-> STAMP != $past(STAMP); endproperty
  a_step: assert property (p_step) else $error("time did not move");
  property p_slock; $rose(SENTENCE_LOCK) |-> $past(NMEA_VALID); endproperty
  a_slock: assert property (p_slock) else $error("lock without char");
  property p_plock; $changed(PULSE_LOCK) |-> SECOND_TICK; endproperty
  a_plock: assert property (p_plock) else $error("lock moved off tick");
endmodule // gts_packet_builder_sva
`default_nettype wire

// *** dv/gts_gps_model.sv ***
// gps receiver model: pulse pin and sentence characters
`timescale 1ns/1ps
`default_nettype none
module gts_gps_model (
  input wire logic clk, // system clock
  output logic pps, // pulse per second
  output logic [7:0] nmea_data, // sentence character
  output logic nmea_valid // one-cycle strobe
);
  int hi; // cycles the pulse has stood
  initial
  begin
    pps = 1'b0;
    nmea_data = 8'h00;
    nmea_valid = 1'b0;
    hi = 0;
  end
  // pulse drops by itself so callers never block on it
  always @(negedge clk)
  begin
    hi <= pps ? hi + 1 : 0;
    if (hi == 7) pps <= 1'b0;
  end
  // callers pulse after the sentence of the second before
  task automatic pulse;
    @(negedge clk);
    pps = 1'b1;
  endtask
  // frame and checksum a body; bad flips the checksum on purpose
  task automatic send(input string body, input bit bad, output string full);
    logic [7:0] ck;
    int i;
    ck = 8'h00;
    for (i = 0; i < body.len(); i++) ck ^= body[i];
    if (bad) ck = ~ck;
    full = $sformatf("$%s*%02X", body, ck);
    for (i = 0; i < full.len(); i++)
    begin
      @(negedge clk);
      nmea_data = full[i];
      nmea_valid = 1'b1;
      @(negedge clk);
      nmea_data = ~full[i]; // no stale character when idle
      nmea_valid = 1'b0;
    end
  endtask
endmodule // gts_gps_model
`default_nettype wire

// *** dv/gts_packet_builder_bench.sv ***
// self-checking bench of the gps time-status packet builder
`timescale 1ns/1ps
`default_nettype none
module gts_packet_builder_bench;
  // ------------------------------------------------------------
  // wiring
  // ------------------------------------------------------------
  logic clk, rst, pps, nmea_valid, tx_valid, tx_last, tx_ready, plock, slock, tick;
  logic [7:0] nmea_data, tx_data; // characters and frame bytes
  logic [31:0] usec; // stamp microseconds
  gts_pkg::gts_time_s stamp; // stamp seen
  int errors, n_checks; // mismatch and comparison counts
  logic [7:0] fr [554]; // captured frame
  string snt; // last full sentence sent
  gts_packet_builder #(.CLK_HZ(2000000)) i_gts_packet_builder (.CLK(clk), .SYS_RST(rst),
    .PPS_IN(pps), .NMEA_DATA(nmea_data), .NMEA_VALID(nmea_valid), .TX_DATA(tx_data),
    .TX_VALID(tx_valid), .TX_LAST(tx_last), .TX_READY(tx_ready), .STAMP(stamp),
    .STAMP_USEC(usec), .PULSE_LOCK(plock), .SENTENCE_LOCK(slock), .SECOND_TICK(tick));
  gts_gps_model i_gts_gps_model (.clk(clk), .pps(pps), .nmea_data(nmea_data),
    .nmea_valid(nmea_valid));
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic cmp(input string what, input logic [47:0] exp, input logic [47:0] got);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // ascii ones digit then tens digit
  function automatic logic [15:0] dig(input logic [7:0] v);
    return {8'h30 + v % 8'h0A, 8'h30 + v / 8'h0A};
  endfunction
  function automatic logic [47:0] pick(input int a, input int n);
    logic [47:0] r;
    r = '0;
    for (int i = 0; i < n; i++) r = {r[39:0], fr[a + i]};
    return r;
  endfunction
  // pulse, then bounded wait for the tick and the stamp check
  task automatic tick_and_stamp(input logic [47:0] exp);
    int i;
    i_gts_gps_model.pulse();
    for (i = 0; i < 40 && tick !== 1'b1; i++) @(negedge clk);
    if (tick !== 1'b1)
    begin
      errors++;
      report_and_stop();
    end
    cmp("stamp", exp, stamp);
  endtask
  // take one frame, stalling every fifth cycle
  task automatic get_frame;
    int n, k, lastpos;
    n = 0;
    lastpos = -1;
    for (k = 0; k < 3000 && n < 554; k++)
    begin
      @(negedge clk);
      tx_ready = (k % 5 != 3);
      if (tx_valid === 1'b1 && tx_ready)
      begin
        fr[n] = tx_data;
        if (tx_last === 1'b1) lastpos = n;
        n++;
      end
    end
    if (n < 554)
    begin
      errors++;
      report_and_stop();
    end
    cmp("last flag position", 48'(553), 48'(lastpos));
  endtask
  task automatic check_frame(input gts_pkg::gts_time_s t, input logic [7:0] st, input logic [7:0] lk,
                             input string s);
    get_frame();
    cmp("dest mac", 48'hFFFF_FFFF_FFFF, pick(0, 6));
    cmp("ether type", 48'h0800, pick(12, 2));
    cmp("source ip", 48'hC0A8_01C9, pick(26, 4));
    cmp("dest ip", 48'hFFFF_FFFF, pick(30, 4));
    cmp("ports", 48'h2710_277E, pick(34, 4));
    cmp("udp length", 48'h0208, pick(38, 2));
    cmp("time head", 48'hFFEE, pick(42, 2));
    cmp("date", {dig(t.year), dig(t.month), dig(t.day)}, pick(44, 6));
    cmp("time", {dig(t.second), dig(t.minute), dig(t.hour)}, pick(50, 6));
    cmp("usec upper", 48'h0, pick(57, 3));
    for (int i = 0; i < 84; i++) cmp("sentence", i < s.len() ? s[i] : 8'h00, fr[60 + i]);
    for (int i = 144; i < 554; i++)
      cmp("tail", i < 548 ? 8'hDF : i == 548 ? st : i == 549 ? lk : 8'h00, fr[i]);
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_synthetic;
    cmp("reset stamp", 48'h1405_1400_0000, stamp);
    tick_and_stamp(48'h1405_1400_0001);
    check_frame(48'h1405_1400_0001, 8'h00, 8'h01, "");
  endtask
  // year, month and day roll over together
  task automatic t_rmc;
    i_gts_gps_model.send("GPRMC,235959.50,A,,,,,,,311299,,", 1'b0, snt);
    repeat (2) @(negedge clk);
    cmp("sentence lock", 48'h1, slock);
    tick_and_stamp(48'h0001_0100_0000);
    check_frame(48'h0001_0100_0000, 8'h41, 8'h01, snt);
  endtask
  task automatic t_gga;
    i_gts_gps_model.send("GPGGA,123519.00,4807.038,N,01131.000,E,1,08,0.9,545.4,M,46.9,M,,",
                         1'b0, snt);
    tick_and_stamp(48'h0001_010C_2314);
    check_frame(48'h0001_010C_2314, 8'h31, 8'h01, snt);
  endtask
  // corrupt checksum: lock drops, time only counts on
  task automatic t_badck;
    i_gts_gps_model.send("GPRMC,010203,V,,,,,,,020304,,", 1'b1, snt);
    repeat (2) @(negedge clk);
    cmp("sentence lock", 48'h0, slock);
    tick_and_stamp(48'h0001_010C_2315);
  endtask
  initial
  begin
    errors = 0;
    n_checks = 0;
    tx_ready = 1'b1;
    rst = 1'b1;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    t_synthetic();
    t_rmc();
    t_gga();
    t_badck();
    report_and_stop();
  end
endmodule // gts_packet_builder_bench
bind gts_packet_builder gts_packet_builder_sva i_gts_packet_builder_sva (.CLK(CLK),
  .SYS_RST(SYS_RST), .PPS_IN(PPS_IN), .NMEA_VALID(NMEA_VALID), .TX_DATA(TX_DATA),
  .TX_VALID(TX_VALID), .TX_LAST(TX_LAST), .TX_READY(TX_READY), .STAMP(STAMP),
  .STAMP_USEC(STAMP_USEC), .PULSE_LOCK(PULSE_LOCK), .SENTENCE_LOCK(SENTENCE_LOCK),
  .SECOND_TICK(SECOND_TICK));
`default_nettype wire
